// ### design/sfas_pkg.sv
// Package with addresses, field positions and reset values of the shared-address decoder.
package sfas_pkg;
    localparam logic [11:0] ADDR_TIMER4_PERIOD = 12'hF77;
    localparam logic [11:0] ADDR_CONV_ONE = 12'hFC1;
    localparam logic [11:0] ADDR_CONV_ZERO = 12'hFC2;
    localparam logic [11:0] ADDR_TIMER2_PERIOD = 12'hFCB;
    localparam logic [11:0] ADDR_TIMER2_COUNT = 12'hFCC;
    localparam logic [11:0] ADDR_TIMER1_CONTROL = 12'hFCD;
    localparam logic [11:0] ADDR_TIMER1_LOW = 12'hFCE;
    localparam logic [11:0] ADDR_TIMER1_HIGH = 12'hFCF;
    localparam logic [11:0] ADDR_OSC_CONTROL = 12'hFD3;
    localparam logic [11:0] ADDR_WATCHDOG = 12'hFC0;
    localparam logic [11:0] ADDR_SERIAL_ADDRESS = 12'hFC8;
    localparam logic [11:0] ADDR_PARPORT_HIGH = 12'hF69;
    localparam logic [11:0] ADDR_PARPORT_LOW = 12'hF68;
    localparam int SHARED_COUNT = 9;
    localparam int BIT_REG_LOW_POWER = 7;
    localparam int BIT_SUPPLY_STATUS = 6;
    localparam int BIT_ALT_SELECT = 4;
    localparam int BIT_SOFT_WATCHDOG = 0;
    localparam logic [7:0] WATCHDOG_WRITE_MASK = 8'h91;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [3:0] MASK_MODE_CODE = 4'h9;
    typedef enum logic [0:0] {
        SFAS_BANK_DEFAULT = 1'b0,
        SFAS_BANK_ALTERNATE = 1'b1
    } sfas_bank_type;
endpackage

// ### design/sfas_reg_file.sv
// Small register memory holding the default and alternate shared registers.
`timescale 1ns/10ps
module sfas_reg_file
    import sfas_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic writeEn,
    input wire logic [4:0] writeIndex,
    input wire logic [7:0] writeData,
    input wire logic [4:0] readIndex,
    output logic [7:0] readData_r
);
    logic [7:0] storeMem [0:31];

    // Every entry clears at reset so reads of untouched registers are defined.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : gEntry
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    storeMem[gi] <= REG_RESET;
                end else if (writeEn && writeIndex == 5'(gi)) begin
                    storeMem[gi] <= writeData;
                end
            end
        end
    endgenerate

    // Read data is registered, so data appears one cycle after the request.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readData_r <= REG_RESET;
        end else begin
            readData_r <= storeMem[readIndex];
        end
    end
endmodule // sfas_reg_file

// ### design/sfas_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/10ps
module sfas_sync
    import sfas_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic asyncIn,
    output logic syncOut_r
);
    logic stageOne_r;

    // The first stage is read only by the second one.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stageOne_r <= 1'b0;
            syncOut_r <= 1'b0;
        end else begin
            stageOne_r <= asyncIn;
            syncOut_r <= stageOne_r;
        end
    end
endmodule // sfas_sync

// ### design/sfas_decoder.sv
// Shared special-function-register address decoder with the watchdog control register.
//
// What this block does
// - With the select bit clear, shared addresses reach only their default register.
// - With the select bit set, shared addresses reach only their alternate register.
// - The select bit is read/write at bit 4 of watchdog control and clears at reset.
// - Nine addresses are shared between a default and an alternate register.
// - The alternate memory-control register exists only in the larger pin variant.
// - Slave address and address mask sit behind one address, picked by serial mode.
// - Parallel address pair and second output pair are one storage, used by port mode.
// - Bit 6 of watchdog control is a read-only supply status flag.
// - Bits 5 and 3 to 1 of watchdog control ignore writes and read zero.
// - Bit 7 is regulator low power and bit 0 software watchdog, both read/write, reset 0.
// - The select bit holds until software changes it; software checks it before use.
// - Unused addresses are unimplemented and read zero.
`timescale 1ns/10ps
module sfas_decoder
    import sfas_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic accessEn,
    input wire logic writeEn,
    input wire logic [11:0] address,
    input wire logic [7:0] writeData,
    input wire logic [3:0] serialModeBits,
    input wire logic parallelSlaveMode,
    input wire logic coreSupplyOk,
    output logic [7:0] readData_r,
    output logic readValid_r,
    output logic alternateSelect_r,
    output logic regulatorLowPower_r,
    output logic softwareWatchdogEnable_r,
    output logic [15:0] parallelPortWord_r,
    output logic [7:0] serialSlaveAddress_r,
    output logic [7:0] serialAddressMask_r
);
    sfas_bank_type bank;
    logic supplyStatus;
    logic sharedHit;
    logic [3:0] sharedSlot;
    logic slotPresent;
    logic [4:0] storeIndex;
    logic storeWrite;
    logic [7:0] storeData;
    logic maskSelected;
    logic [1:0] readSource_r;
    logic [1:0] readSource_nxt;
    logic [7:0] localData_r;
    logic [7:0] localData_nxt;
    logic [7:0] watchdogImage;
    logic [7:0] storeReadData;

    // The supply comparator lives in the analog domain, so it is synchronised.
    sfas_sync uSupplySync (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn(coreSupplyOk),
        .syncOut_r(supplyStatus)
    );

    // Bank choice follows only the select bit and changes nothing else.
    assign bank = alternateSelect_r ? SFAS_BANK_ALTERNATE : SFAS_BANK_DEFAULT;

    // Map the nine shared addresses to slots; others fall out of this path.
    always_comb begin
        sharedHit = 1'b1;
        sharedSlot = 4'h0;
        case (address)
            ADDR_OSC_CONTROL: sharedSlot = 4'h0;
            ADDR_TIMER1_HIGH: sharedSlot = 4'h1;
            ADDR_TIMER1_LOW: sharedSlot = 4'h2;
            ADDR_TIMER1_CONTROL: sharedSlot = 4'h3;
            ADDR_TIMER2_COUNT: sharedSlot = 4'h4;
            ADDR_TIMER2_PERIOD: sharedSlot = 4'h5;
            ADDR_CONV_ZERO: sharedSlot = 4'h6;
            ADDR_CONV_ONE: sharedSlot = 4'h7;
            ADDR_TIMER4_PERIOD: sharedSlot = 4'h8;
            default: sharedHit = 1'b0;
        endcase
    end

    // The alternate memory-control slot is absent in the small variant and reads zero.
    assign slotPresent = !(sharedSlot == 4'h5 && bank == SFAS_BANK_ALTERNATE
        && !LARGE_VARIANT);

    // The bank bit picks one entry of the pair, so the other is never touched.
    assign storeIndex = {bank, sharedSlot};
    assign storeWrite = accessEn && writeEn && sharedHit && slotPresent;
    assign storeData = writeData;

    sfas_reg_file uStore (
        .clk(clk),
        .reset_n(reset_n),
        .writeEn(storeWrite),
        .writeIndex(storeIndex),
        .writeData(storeData),
        .readIndex(storeIndex),
        .readData_r(storeReadData)
    );

    // The serial mode code, not the select bit, picks mask or address.
    assign maskSelected = (serialModeBits == MASK_MODE_CODE);

    // Watchdog control as seen by a read; unimplemented bits are zero.
    always_comb begin
        watchdogImage = 8'h00;
        watchdogImage[BIT_REG_LOW_POWER] = regulatorLowPower_r;
        watchdogImage[BIT_SUPPLY_STATUS] = supplyStatus;
        watchdogImage[BIT_ALT_SELECT] = alternateSelect_r;
        watchdogImage[BIT_SOFT_WATCHDOG] = softwareWatchdogEnable_r;
    end

    // Writable watchdog bits; only masked bits take write data.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            alternateSelect_r <= 1'b0;
            regulatorLowPower_r <= 1'b0;
            softwareWatchdogEnable_r <= 1'b0;
        end else if (accessEn && writeEn && address == ADDR_WATCHDOG) begin
            alternateSelect_r <= writeData[BIT_ALT_SELECT] & WATCHDOG_WRITE_MASK[BIT_ALT_SELECT];
            regulatorLowPower_r <= writeData[BIT_REG_LOW_POWER];
            softwareWatchdogEnable_r <= writeData[BIT_SOFT_WATCHDOG];
        end
    end

    // Serial slave address and mask are two registers behind one address.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            serialSlaveAddress_r <= REG_RESET;
            serialAddressMask_r <= REG_RESET;
        end else if (accessEn && writeEn && address == ADDR_SERIAL_ADDRESS) begin
            if (maskSelected) begin
                serialAddressMask_r <= writeData;
            end else begin
                serialSlaveAddress_r <= writeData;
            end
        end
    end

    // One physical pair serves as address or second output data; mode only
    // changes how the port uses it, so storage ignores the mode.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            parallelPortWord_r <= 16'h0000;
        end else if (accessEn && writeEn && address == ADDR_PARPORT_HIGH) begin
            parallelPortWord_r[15:8] <= writeData;
        end else if (accessEn && writeEn && address == ADDR_PARPORT_LOW) begin
            parallelPortWord_r[7:0] <= writeData;
        end
    end

    // Read source: 0 none, 1 shared store, 2 local register.
    always_comb begin
        readSource_nxt = 2'h0;
        localData_nxt = 8'h00;
        if (accessEn && !writeEn) begin
            if (sharedHit && slotPresent) begin
                readSource_nxt = 2'h1;
            end else if (address == ADDR_WATCHDOG) begin
                readSource_nxt = 2'h2;
                localData_nxt = watchdogImage;
            end else if (address == ADDR_SERIAL_ADDRESS) begin
                readSource_nxt = 2'h2;
                localData_nxt = maskSelected ? serialAddressMask_r : serialSlaveAddress_r;
            end else if (address == ADDR_PARPORT_HIGH) begin
                readSource_nxt = 2'h2;
                localData_nxt = parallelPortWord_r[15:8];
            end else if (address == ADDR_PARPORT_LOW) begin
                readSource_nxt = 2'h2;
                localData_nxt = parallelPortWord_r[7:0];
            end
        end
    end

    // Stage one registers the source; store data arrives at the same time.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readSource_r <= 2'h0;
            localData_r <= 8'h00;
        end else begin
            readSource_r <= readSource_nxt;
            localData_r <= localData_nxt;
        end
    end

    // Stage two presents the answer; unused addresses read zero.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            readData_r <= 8'h00;
            readValid_r <= 1'b0;
        end else begin
            readValid_r <= readSource_r != 2'h0;
            case (readSource_r)
                2'h1: readData_r <= storeReadData;
                2'h2: readData_r <= localData_r;
                default: readData_r <= 8'h00;
            endcase
        end
    end

    // Checks on the decode and the control bits.
    chk_select_reset: assert property (@(posedge clk) !reset_n |=> !alternateSelect_r)
        else $error("select bit not clear after reset");
    chk_select_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !(accessEn && writeEn && address == ADDR_WATCHDOG) |=> $stable(alternateSelect_r))
        else $error("select bit changed without a write");
    chk_select_write: assert property (@(posedge clk) disable iff (!reset_n)
        accessEn && writeEn && address == ADDR_WATCHDOG |=>
        alternateSelect_r == $past(writeData[BIT_ALT_SELECT]))
        else $error("select bit did not take written value");
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (!reset_n)
        accessEn && !writeEn && address == ADDR_WATCHDOG ##2 1'b1 |->
        (readData_r & 8'h2E) == 8'h00)
        else $error("unimplemented watchdog bits read nonzero");
    chk_default_bank: assert property (@(posedge clk) disable iff (!reset_n)
        storeWrite && !alternateSelect_r |-> !storeIndex[4])
        else $error("default bank write went to alternate entry");
    chk_alternate_bank: assert property (@(posedge clk) disable iff (!reset_n)
        storeWrite && alternateSelect_r |-> storeIndex[4])
        else $error("alternate bank write went to default entry");
    chk_unused_zero: assert property (@(posedge clk) disable iff (!reset_n)
        accessEn && !writeEn && address == 12'hFD4 |-> ##2 (readData_r == 8'h00 && !readValid_r))
        else $error("unused address read nonzero");
    chk_mask_select: assert property (@(posedge clk) disable iff (!reset_n)
        accessEn && writeEn && address == ADDR_SERIAL_ADDRESS && maskSelected |=>
        $stable(serialSlaveAddress_r))
        else $error("mask-mode write disturbed slave address");
    chk_small_variant: assert property (@(posedge clk) disable iff (!reset_n)
        !LARGE_VARIANT && alternateSelect_r && address == ADDR_TIMER2_PERIOD |-> !storeWrite)
        else $error("memory-control write in small variant");
    chk_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
        accessEn && !writeEn && address == ADDR_WATCHDOG |-> ##2 readValid_r)
        else $error("watchdog control read missing");

    cov_alt_write: cover property (@(posedge clk) storeWrite && alternateSelect_r);
    cov_default_read: cover property (@(posedge clk) readValid_r && !alternateSelect_r);
    cov_mask_write: cover property (@(posedge clk) accessEn && writeEn && maskSelected);
endmodule // sfas_decoder

// ### verif/sfas_core_model.sv
// Core-side model that issues register reads and writes to the decoder.
`timescale 1ns/10ps
module sfas_core_model
    import sfas_pkg::*;
(
    input wire logic clk,
    output logic accessEn,
    output logic writeEn,
    output logic [11:0] address,
    output logic [7:0] writeData,
    input wire logic [7:0] readData_r,
    input wire logic readValid_r
);
    // Idle values at time zero.
    initial begin
        accessEn = 1'b0;
        writeEn = 1'b0;
        address = 12'h000;
        writeData = 8'h00;
    end

    // One-cycle write; released lines show the inverse so stale values never pass.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        accessEn = 1'b1;
        writeEn = 1'b1;
        address = a;
        writeData = d;
        @(negedge clk);
        accessEn = 1'b0;
        writeEn = 1'b0;
        address = ~a;
        writeData = ~d;
    endtask

    // One-cycle read; the answer stands for one cycle after the second rising edge.
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        accessEn = 1'b1;
        writeEn = 1'b0;
        address = a;
        @(negedge clk);
        accessEn = 1'b0;
        address = ~a;
        @(negedge clk);
        d = readData_r;
        v = readValid_r;
    endtask
endmodule // sfas_core_model

// ### verif/test_shared_sfr_address_select.sv
// Self-checking bench for the shared-address decoder.
`timescale 1ns/10ps
module test_shared_sfr_address_select
    import sfas_pkg::*;
;
    logic clk, reset_n, accessEn, writeEn, parallelSlaveMode, coreSupplyOk;
    logic [11:0] address;
    logic [7:0] writeData, readData_r, slaveAddr, maskReg, rdat;
    logic [3:0] serialModeBits;
    logic readValid_r, altSel, lowPow, swdEn, rval;
    logic [15:0] parWord;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    logic [11:0] shared [9] = '{12'hFD3, 12'hFCF, 12'hFCE, 12'hFCD, 12'hFCC,
                                 12'hFCB, 12'hFC2, 12'hFC1, 12'hF77};

    sfas_core_model u_core (.clk(clk), .accessEn(accessEn), .writeEn(writeEn),
        .address(address), .writeData(writeData), .readData_r(readData_r),
        .readValid_r(readValid_r));
    sfas_decoder #(.LARGE_VARIANT(1'b1)) u_dut (.clk(clk), .reset_n(reset_n),
        .accessEn(accessEn), .writeEn(writeEn), .address(address), .writeData(writeData),
        .serialModeBits(serialModeBits), .parallelSlaveMode(parallelSlaveMode),
        .coreSupplyOk(coreSupplyOk), .readData_r(readData_r), .readValid_r(readValid_r),
        .alternateSelect_r(altSel), .regulatorLowPower_r(lowPow),
        .softwareWatchdogEnable_r(swdEn), .parallelPortWord_r(parWord),
        .serialSlaveAddress_r(slaveAddr), .serialAddressMask_r(maskReg));

    // Clock at 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // A hang is cut short well beyond the under two hundred cycles the run needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads a register and compares both data and the valid pulse.
    task automatic rd_check(input logic [11:0] a, input logic [7:0] exp, input logic v);
        u_core.rd(a, rdat, rval);
        check($sformatf("read %h", a), {8'h00, exp}, {8'h00, rdat});
        check($sformatf("valid %h", a), {15'h0, v}, {15'h0, rval});
    endtask

    // Software looks at the select bit before it changes it, then writes it.
    task automatic set_select(input logic b);
        u_core.rd(ADDR_WATCHDOG, rdat, rval);
        u_core.wr(ADDR_WATCHDOG, {3'b000, b, 4'h0});
        check("select", {15'h0, b}, {15'h0, altSel});
    endtask

    task automatic reset_values();
        check("outputs", 16'h0000, {altSel, lowPow, swdEn, slaveAddr, maskReg[4:0]});
        rd_check(ADDR_WATCHDOG, 8'h40, 1'b1);
    endtask

    task automatic watchdog_bits();
        u_core.wr(ADDR_WATCHDOG, 8'hFF);
        rd_check(ADDR_WATCHDOG, 8'hD1, 1'b1);
        check("bit7 bit0", 16'h0003, {14'h0, lowPow, swdEn});
        coreSupplyOk = 1'b0;
        repeat (4) @(negedge clk);
        rd_check(ADDR_WATCHDOG, 8'h91, 1'b1);
        u_core.wr(ADDR_WATCHDOG, 8'h00);
        rd_check(ADDR_WATCHDOG, 8'h00, 1'b1);
        coreSupplyOk = 1'b1;
    endtask

    // Each shared address holds two independent values chosen by the select bit.
    task automatic shared_pairs();
        set_select(1'b0);
        foreach (shared[i]) u_core.wr(shared[i], 8'h10 + 8'(i));
        set_select(1'b1);
        foreach (shared[i]) u_core.wr(shared[i], 8'hA0 + 8'(i));
        foreach (shared[i]) rd_check(shared[i], 8'hA0 + 8'(i), 1'b1);
        set_select(1'b0);
        foreach (shared[i]) rd_check(shared[i], 8'h10 + 8'(i), 1'b1);
    endtask

    // Mode-selected registers ignore the select bit.
    task automatic mode_regs();
        u_core.wr(ADDR_SERIAL_ADDRESS, 8'h5A);
        serialModeBits = MASK_MODE_CODE;
        u_core.wr(ADDR_SERIAL_ADDRESS, 8'hC3);
        check("serial pair", 16'h5AC3, {slaveAddr, maskReg});
        rd_check(ADDR_SERIAL_ADDRESS, 8'hC3, 1'b1);
        serialModeBits = 4'h0;
        set_select(1'b1);
        rd_check(ADDR_SERIAL_ADDRESS, 8'h5A, 1'b1);
        u_core.wr(ADDR_PARPORT_HIGH, 8'h12);
        parallelSlaveMode = 1'b1;
        u_core.wr(ADDR_PARPORT_LOW, 8'h34);
        check("parallel word", 16'h1234, parWord);
        parallelSlaveMode = 1'b0;
        rd_check(ADDR_PARPORT_LOW, 8'h34, 1'b1);
        set_select(1'b0);
    endtask

    task automatic unmapped();
        u_core.wr(12'hFD4, 8'h77);
        rd_check(12'hFD4, 8'h00, 1'b0);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence: reset for 12 cycles, then the scenarios.
    initial begin
        reset_n = 1'b0;
        serialModeBits = 4'h0;
        parallelSlaveMode = 1'b0;
        coreSupplyOk = 1'b1;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        reset_values();
        watchdog_bits();
        shared_pairs();
        mode_regs();
        unmapped();
        wrap_up();
    end
endmodule // test_shared_sfr_address_select
